// *** branch_bit_flag_exec.sv ***
// Execution unit for flag branches, I/O bit ops, shifts, T-bit moves and flag set/clear
// Function
// - Generic branches taken when selected flag clear or set
// - Equal/not-equal branch on zero flag
// - Carry and unsigned branches on carry flag
// - Minus/plus branch on negative flag
// - Signed branches on negative xor overflow
// - Half-carry branches on half-carry flag
// - Transfer-bit branches on T flag
// - Overflow branches on overflow flag
// - Interrupt branches on global enable flag
// - I/O bit set, two cycles, no flags
// - I/O bit clear, two cycles, no flags
// - Logical shifts fill zero, update ZCNV
// - Left rotate through carry, update ZCNV
// - Right rotate through carry, update ZCNV
// - Arithmetic right shift keeps bit seven
// - Register bit copied into T flag
// - T flag copied into register bit
// - Set or clear exactly one status flag
module branch_bit_flag_exec
    import branch_bit_flag_pkg::*;
#(
    parameter int PC_W   = 12,                 // Program counter width in words
    parameter int OFFS_W = 7,                  // Branch offset width
    parameter int CNT_W  = 16                  // Retired instruction counter width
) (
    input  wire logic              pclk,          // Core clock
    input  wire logic              presetn,       // Async reset, active low
    input  wire logic              ce,            // Clock enable, freezes state
    input  wire logic              psel,          // APB select
    input  wire logic              penable,       // APB enable
    input  wire logic              pwrite,        // APB direction
    input  wire logic [7:0]        paddr,         // APB byte address
    input  wire logic [31:0]       pwdata,        // APB write data
    output logic                   pready,        // APB ready
    output logic      [31:0]       prdata,        // APB read data
    output logic                   pslverr,       // APB error, unmapped address
    input  wire logic              instr_valid,   // Decoded instruction present
    input  wire op_t               instr_op,      // Operation
    input  wire logic [2:0]        instr_flag,    // Flag index
    input  wire logic [2:0]        instr_bit,     // Bit index
    input  wire logic [OFFS_W-1:0] instr_offset,  // Signed branch offset
    input  wire logic [4:0]        instr_dst,     // Destination register
    input  wire logic [4:0]        instr_io_addr, // I/O register address
    input  wire logic [7:0]        reg_rdata,     // Source register value
    input  wire logic [7:0]        io_rdata,      // Addressed I/O register value
    output logic                   instr_ready,   // Unit accepts an instruction
    output logic                   rd_we,         // Register write pulse
    output logic      [4:0]        rd_waddr,      // Register write address
    output logic      [7:0]        rd_wdata,      // Register write data
    output logic                   io_we,         // I/O write pulse
    output logic      [4:0]        io_waddr,      // I/O write address
    output logic      [7:0]        io_wdata,      // I/O write data
    output logic      [PC_W-1:0]   pc,            // Program counter
    output logic                   pc_load,       // Pulse when a branch reloads pc
    output logic      [7:0]        status_register // Status flags
);

    typedef enum logic {st_run, st_stall} exec_state_t;

    exec_state_t      state;
    logic             ctrl_run;
    logic [CNT_W-1:0] retired;

    logic             accept;
    logic             is_branch;
    logic             taken;
    logic             multi;
    logic             res_we;
    logic             io_wr;

    logic [7:0]       next_status;
    logic [7:0]       next_res;
    logic [7:0]       next_io;
    logic [PC_W-1:0]  pc_inc;
    logic [PC_W-1:0]  pc_target;

    logic             apb_acc;
    logic             apb_wr;
    logic             apb_hit;
    logic [31:0]      apb_rd;

    // Branch decode: bit1 = is a branch, bit0 = condition true
    function automatic logic [1:0] branch_test(op_t op, logic [2:0] sel, logic [7:0] sr);
        logic [1:0] r;
        r = 2'b00;

        case (op)
            op_branch_flag_clear_generic:   r = {1'b1, ~sr[sel]};
            op_branch_flag_set_generic:     r = {1'b1, sr[sel]};
            op_branch_on_equal:             r = {1'b1, sr[FLAG_Z]};
            op_branch_on_not_equal:         r = {1'b1, ~sr[FLAG_Z]};
            op_branch_on_carry_one:         r = {1'b1, sr[FLAG_C]};
            op_branch_unsigned_lower:       r = {1'b1, sr[FLAG_C]};
            op_branch_on_carry_zero:        r = {1'b1, ~sr[FLAG_C]};
            op_branch_unsigned_same_higher: r = {1'b1, ~sr[FLAG_C]};
            op_branch_on_negative:          r = {1'b1, sr[FLAG_N]};
            op_branch_on_positive:          r = {1'b1, ~sr[FLAG_N]};
            op_branch_signed_ge:            r = {1'b1, ~(sr[FLAG_N] ^ sr[FLAG_V])};
            op_branch_signed_lt:            r = {1'b1, sr[FLAG_N] ^ sr[FLAG_V]};
            op_branch_half_carry_one:       r = {1'b1, sr[FLAG_H]};
            op_branch_half_carry_zero:      r = {1'b1, ~sr[FLAG_H]};
            op_branch_transfer_bit_one:     r = {1'b1, sr[FLAG_T]};
            op_branch_transfer_bit_zero:    r = {1'b1, ~sr[FLAG_T]};
            op_branch_overflow_one:         r = {1'b1, sr[FLAG_V]};
            op_branch_overflow_zero:        r = {1'b1, ~sr[FLAG_V]};
            op_branch_irq_enabled:          r = {1'b1, sr[FLAG_I]};
            op_branch_irq_disabled:         r = {1'b1, ~sr[FLAG_I]};
            default:                        r = 2'b00;
        endcase
        return r;
    endfunction

    // Shift and rotate: returns {carry out, result}
    function automatic logic [8:0] shift_calc(op_t op, logic [7:0] d, logic c);
        logic [8:0] r;
        r = {c, d};

        case (op)
            op_shift_left_logical:  r = {d[7], d[6:0], 1'b0};
            op_shift_right_logical: r = {d[0], 1'b0, d[7:1]};
            op_rotate_left_carry:   r = {d[7], d[6:0], c};
            op_rotate_right_carry:  r = {d[0], c, d[7:1]};
            op_shift_right_arith:   r = {d[0], d[7], d[7:1]};
            default:                r = {c, d};
        endcase
        return r;
    endfunction

    // Sign-extend the branch offset to pc width
    function automatic logic [PC_W-1:0] sext_offset(logic [OFFS_W-1:0] k);
        return {{(PC_W - OFFS_W){k[OFFS_W-1]}}, k};
    endfunction

    // Map a register offset to its read value, bit32 flags a hit
    function automatic logic [32:0] reg_read(logic [7:0] a, logic run, logic [7:0] sr,
                                             logic [PC_W-1:0] p, logic [CNT_W-1:0] n,
                                             logic busy);
        logic [32:0] r;
        r = '0;

        case (a)
            ADDR_CTRL:   r = {1'b1, 30'h0, busy, run};
            ADDR_STATUS: r = {1'b1, 24'h0, sr};
            ADDR_PC:     r = {1'b1, {(32 - PC_W){1'b0}}, p};
            ADDR_COUNT:  r = {1'b1, {(32 - CNT_W){1'b0}}, n};
            default:     r = '0;
        endcase
        return r;
    endfunction

    // Instruction handshake and pc arithmetic
    assign accept    = ce & instr_valid & instr_ready;
    assign pc_inc    = pc + {{(PC_W - 1){1'b0}}, 1'b1};
    assign pc_target = pc_inc + sext_offset(instr_offset);

    // Execute: flag, register and I/O results of the issued instruction
    always_comb begin
        logic [1:0] bt;
        logic [8:0] sh;
        bt          = branch_test(instr_op, instr_flag, status_register);
        sh          = shift_calc(instr_op, reg_rdata, status_register[FLAG_C]);
        is_branch   = bt[1];
        taken       = bt[1] & bt[0];
        next_status = status_register;
        next_res    = reg_rdata;
        next_io     = io_rdata;
        res_we      = 1'b0;
        io_wr       = 1'b0;
        case (instr_op)
            op_io_bit_force_one: begin
                next_io         = io_rdata;
                next_io[instr_bit] = 1'b1;
                io_wr           = 1'b1;
            end

            op_io_bit_force_zero: begin
                next_io         = io_rdata;
                next_io[instr_bit] = 1'b0;
                io_wr           = 1'b1;
            end

            op_shift_left_logical,
            op_shift_right_logical,
            op_rotate_left_carry,
            op_rotate_right_carry,
            op_shift_right_arith: begin
                next_res            = sh[7:0];
                res_we              = 1'b1;
                next_status[FLAG_C] = sh[8];
                next_status[FLAG_Z] = (sh[7:0] == 8'h00);
                next_status[FLAG_N] = sh[7];
                next_status[FLAG_V] = sh[7] ^ sh[8];
            end

            op_bit_to_transfer_flag: begin
                next_status[FLAG_T] = reg_rdata[instr_bit];
            end

            op_transfer_flag_to_bit: begin
                next_res            = reg_rdata;
                next_res[instr_bit] = status_register[FLAG_T];
                res_we              = 1'b1;
            end

            op_flag_force_one_indexed,
            op_flag_force_one_named: begin
                next_status[instr_flag] = 1'b1;
            end

            op_flag_force_zero_indexed,
            op_flag_force_zero_named: begin
                next_status[instr_flag] = 1'b0;
            end

            op_global_irq_on: begin
                next_status[FLAG_I] = 1'b1;
            end

            op_global_irq_off: begin
                next_status[FLAG_I] = 1'b0;
            end

            default: begin
                next_status = status_register;
            end
        endcase
    end

    // Taken branches and I/O bit ops occupy a second cycle
    assign multi = taken | io_wr;

    // APB decode: access phase, completing edge and address hit
    assign apb_acc = psel & penable;
    assign apb_wr  = apb_acc & pready & pwrite;
    assign {apb_hit, apb_rd} = reg_read(paddr, ctrl_run, status_register, pc, retired,
                                        state == st_stall);

    // Sequencer: one stall cycle after a multi-cycle instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= st_run;
            instr_ready <= 1'b0;
        end else if (ce) begin
            case (state)
                st_run: begin
                    if (accept && multi) begin
                        state       <= st_stall;
                        instr_ready <= 1'b0;
                    end else begin
                        instr_ready <= ctrl_run;
                    end
                end

                st_stall: begin
                    state       <= st_run;
                    instr_ready <= ctrl_run;
                end

                default: begin
                    state       <= st_run;
                    instr_ready <= 1'b0;
                end
            endcase
        end
    end

    // Program counter: advance by one, or reload on a taken branch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc      <= '0;
            pc_load <= 1'b0;
        end else if (ce) begin
            pc_load <= accept & taken;

            if (accept) begin
                pc <= taken ? pc_target : pc_inc;
            end else if (apb_wr && paddr == ADDR_PC) begin
                pc <= pwdata[PC_W-1:0];
            end
        end
    end

    // Status flags: an executing non-branch instruction wins over a software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_register <= STATUS_RST;
        end else if (ce) begin
            if (accept && !is_branch) begin
                status_register <= next_status;
            end else if (apb_wr && paddr == ADDR_STATUS) begin
                status_register <= pwdata[7:0];
            end
        end
    end

    // Register file write port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_we    <= 1'b0;
            rd_waddr <= 5'h00;
            rd_wdata <= 8'h00;
        end else if (ce) begin
            rd_we <= accept & res_we;

            if (accept && res_we) begin
                rd_waddr <= instr_dst;
                rd_wdata <= next_res;
            end
        end
    end

    // I/O write port, driven in the second cycle of a bit op
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_we    <= 1'b0;
            io_waddr <= 5'h00;
            io_wdata <= 8'h00;
        end else if (ce) begin
            io_we <= accept & io_wr;

            if (accept && io_wr) begin
                io_waddr <= instr_io_addr;
                io_wdata <= next_io;
            end
        end
    end

    // Control register: run enable gates instruction acceptance
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_run <= CTRL_RUN_RST;
        end else if (ce) begin
            if (apb_wr && paddr == ADDR_CTRL) begin
                ctrl_run <= pwdata[CTRL_RUN_BIT];
            end
        end
    end

    // Retired instruction counter, a write clears it; a retire in that cycle counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retired <= '0;
        end else if (ce) begin
            if (apb_wr && paddr == ADDR_COUNT) begin
                retired <= accept ? {{(CNT_W - 1){1'b0}}, 1'b1} : '0;
            end else if (accept) begin
                retired <= retired + {{(CNT_W - 1){1'b0}}, 1'b1};
            end
        end
    end

    // APB slave: one wait state, read data and error captured with ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= apb_acc & ~pready;
            if (apb_acc && !pready) begin
                prdata  <= pwrite ? 32'h0000_0000 : apb_rd;
                pslverr <= ~apb_hit;
            end else begin
                prdata  <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

endmodule

// *** branch_bit_flag_pkg.sv ***
// Constants, opcodes and register map for the branch, bit and flag execution slice
package branch_bit_flag_pkg;

    // Status register flag positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // Register map, byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PC     = 8'h08;
    localparam logic [7:0] ADDR_COUNT  = 8'h0c;

    // Field positions and reset values
    localparam int         CTRL_RUN_BIT = 0;
    localparam logic [7:0] STATUS_RST   = 8'h00;
    localparam logic       CTRL_RUN_RST = 1'b1;

    // Operations issued by the decode path
    typedef enum logic [5:0] {
        op_nop,
        op_branch_flag_clear_generic,
        op_branch_flag_set_generic,
        op_branch_on_equal,
        op_branch_on_not_equal,
        op_branch_on_carry_one,
        op_branch_on_carry_zero,
        op_branch_unsigned_same_higher,
        op_branch_unsigned_lower,
        op_branch_on_negative,
        op_branch_on_positive,
        op_branch_signed_ge,
        op_branch_signed_lt,
        op_branch_half_carry_one,
        op_branch_half_carry_zero,
        op_branch_transfer_bit_one,
        op_branch_transfer_bit_zero,
        op_branch_overflow_one,
        op_branch_overflow_zero,
        op_branch_irq_enabled,
        op_branch_irq_disabled,
        op_io_bit_force_one,
        op_io_bit_force_zero,
        op_shift_left_logical,
        op_shift_right_logical,
        op_rotate_left_carry,
        op_rotate_right_carry,
        op_shift_right_arith,
        op_bit_to_transfer_flag,
        op_transfer_flag_to_bit,
        op_flag_force_one_indexed,
        op_flag_force_zero_indexed,
        op_flag_force_one_named,
        op_flag_force_zero_named,
        op_global_irq_on,
        op_global_irq_off
    } op_t;

endpackage

// *** branch_bit_flag_sva.sv ***
// Checker on the ports of the branch, bit and flag execution slice
module branch_bit_flag_sva
    import branch_bit_flag_pkg::*;
#(
    parameter int PC_W   = 12, // Program counter width
    parameter int OFFS_W = 7   // Branch offset width
) (
    input wire logic              pclk,           // Clock
    input wire logic              presetn,        // Reset, active low
    input wire logic              ce,             // Clock enable
    input wire logic              instr_valid,    // Instruction present
    input wire op_t               instr_op,       // Operation
    input wire logic [2:0]        instr_flag,     // Flag index
    input wire logic [2:0]        instr_bit,      // Bit index
    input wire logic [OFFS_W-1:0] instr_offset,   // Branch offset
    input wire logic [7:0]        reg_rdata,      // Source register
    input wire logic [7:0]        io_rdata,       // I/O register
    input wire logic              instr_ready,    // Unit ready
    input wire logic              rd_we,          // Register write
    input wire logic [7:0]        rd_wdata,       // Register data
    input wire logic              io_we,          // I/O write
    input wire logic [7:0]        io_wdata,       // I/O data
    input wire logic [PC_W-1:0]   pc,             // Program counter
    input wire logic              pc_load,        // Branch reload
    input wire logic [7:0]        status_register // Flags
);
    timeunit 1ns;
    timeprecision 1ps;
    // Accept, branch targets and expected values
    wire logic            acc   = ce && instr_valid && instr_ready;
    wire logic            is_br = instr_op >= op_branch_flag_clear_generic
                                  && instr_op <= op_branch_irq_disabled;
    wire logic [PC_W-1:0] tgt   = pc + PC_W'(1) + PC_W'(signed'(instr_offset));
    wire logic [PC_W-1:0] nxt   = pc + PC_W'(1);
    wire logic            zf    = status_register[FLAG_Z];
    wire logic            nv    = status_register[FLAG_N] ^ status_register[FLAG_V];
    wire logic [7:0]      io_s  = io_rdata | (8'h01 << instr_bit);
    wire logic [7:0]      io_c  = io_rdata & ~(8'h01 << instr_bit);
    wire logic [8:0]      sh9   = {reg_rdata, 1'b0};
    wire logic [7:0]      fs    = status_register | (8'h01 << instr_flag);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_br_pc; acc && is_br |=> pc == (pc_load ? $past(tgt) : $past(nxt)); endproperty
    a_br_pc: assert property (p_br_pc)
        else $error("branch target wrong");
    property p_br_eq; acc && instr_op == op_branch_on_equal |=> pc_load == $past(zf); endproperty
    a_br_eq: assert property (p_br_eq)
        else $error("equal branch decision wrong");
    property p_br_lt; acc && instr_op == op_branch_signed_lt |=> pc_load == $past(nv); endproperty
    a_br_lt: assert property (p_br_lt)
        else $error("signed less branch decision wrong");
    property p_br_hold; acc && is_br |=> $stable(status_register); endproperty
    a_br_hold: assert property (p_br_hold)
        else $error("branch altered flags");
    property p_two; pc_load || io_we |-> !instr_ready; endproperty
    a_two: assert property (p_two)
        else $error("two cycle operation not held");
    property p_io_one;
        acc && instr_op == op_io_bit_force_one |=> io_we && io_wdata == $past(io_s);
    endproperty
    a_io_one: assert property (p_io_one)
        else $error("io bit set wrong");
    property p_io_zero;
        acc && instr_op == op_io_bit_force_zero |=> io_we && io_wdata == $past(io_c);
    endproperty
    a_io_zero: assert property (p_io_zero)
        else $error("io bit clear wrong");
    property p_lsl;
        acc && instr_op == op_shift_left_logical
            |=> rd_we && {status_register[FLAG_C], rd_wdata} == $past(sh9);
    endproperty
    a_lsl: assert property (p_lsl)
        else $error("left shift wrong");
    property p_fset; acc && instr_op == op_flag_force_one_indexed |=> status_register == $past(fs);
    endproperty
    a_fset: assert property (p_fset)
        else $error("indexed flag set wrong");
endmodule

bind branch_bit_flag_exec branch_bit_flag_sva #(.PC_W(PC_W), .OFFS_W(OFFS_W))
    branch_bit_flag_sva_i (.*);

// *** core_side_model.sv ***
// Register file and I/O space model facing the execution slice
module core_side_model (
    input  wire logic       pclk,          // Clock
    input  wire logic [4:0] instr_dst,     // Register read index
    input  wire logic [4:0] instr_io_addr, // I/O read index
    input  wire logic       rd_we,         // Register write
    input  wire logic [4:0] rd_waddr,      // Register write index
    input  wire logic [7:0] rd_wdata,      // Register write data
    input  wire logic       io_we,         // I/O write
    input  wire logic [4:0] io_waddr,      // I/O write index
    input  wire logic [7:0] io_wdata,      // I/O write data
    output logic      [7:0] reg_rdata,     // Register value
    output logic      [7:0] io_rdata       // I/O value
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] regs [32];
    logic [7:0] ios  [32];
    // Preload so no read is unknown
    initial begin
        for (int i = 0; i < 32; i++) begin
            regs[i] = 8'(i * 37 + 5);
            ios[i]  = 8'(i * 91 + 3);
        end
    end
    // Reads follow the index at once; writes land on the clock
    assign reg_rdata = regs[instr_dst];
    assign io_rdata  = ios[instr_io_addr];
    always @(posedge pclk) begin
        if (rd_we)
            regs[rd_waddr] <= rd_wdata;
        if (io_we)
            ios[io_waddr] <= io_wdata;
    end
endmodule

// *** tb.sv ***
// Self-checking bench for the branch, bit and flag execution slice
module tb
    import branch_bit_flag_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
    logic        instr_valid, instr_ready, rd_we, io_we, pc_load;
    logic [7:0]  paddr, reg_rdata, io_rdata, rd_wdata, io_wdata, status_register;
    logic [31:0] pwdata, prdata;
    op_t         instr_op;
    logic [2:0]  instr_flag, instr_bit;
    logic [6:0]  instr_offset;
    logic [4:0]  instr_dst, instr_io_addr, rd_waddr, io_waddr;
    logic [11:0] pc;
    int          mismatches, total_checks, seed;
    // Flag tested and polarity for the named branches, in operation order
    localparam int IDX [18] = '{FLAG_Z, FLAG_Z, FLAG_C, FLAG_C, FLAG_C, FLAG_C, FLAG_N, FLAG_N,
        8, 8, FLAG_H, FLAG_H, FLAG_T, FLAG_T, FLAG_V, FLAG_V, FLAG_I, FLAG_I};
    localparam bit POL [18] = '{1, 0, 1, 0, 0, 1, 1, 0, 0, 1, 1, 0, 1, 0, 1, 0, 1, 0};

    branch_bit_flag_exec branch_bit_flag_exec_i (.*);
    core_side_model core_side_model_i (.*);

    // Free-running core clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Counts a comparison and reports a difference
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Prints the outcome and stops
    task automatic give_verdict();
        if (mismatches == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One bus transfer; reads are compared with the expected word and error
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] eq, input logic ee);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
        if (!w)
            chk({pslverr, prdata}, {ee, eq});
        @(posedge pclk);
    endtask

    // Branch outcome from the flags seen at accept
    function automatic logic br_take(input op_t o, input logic [2:0] f, input logic [7:0] s);
        logic [8:0] x;
        int         k;
        x = {s[FLAG_N] ^ s[FLAG_V], s};
        k = int'(o) - 3;
        if (o == op_branch_flag_clear_generic)
            return !s[f];
        if (o == op_branch_flag_set_generic)
            return s[f];
        if (k < 0 || k > 17)
            return 1'b0;
        return x[IDX[k]] == POL[k];
    endfunction

    // Loads the flags, issues one instruction and checks its effect
    task automatic op(input op_t o, input logic [7:0] sv, input logic [6:0] off);
        logic [7:0]  r, io, s, er, eio, es;
        logic [11:0] p, ep;
        logic [4:0]  d, ia;
        logic [2:0]  f, b;
        logic        tk, wr, wi;
        apb(1'b1, ADDR_STATUS, {24'h0, sv}, 32'h0, 1'b0);
        {f, b, d, ia} = 16'($random(seed));
        {instr_valid, instr_flag, instr_bit, instr_offset} <= {1'b1, f, b, off};
        {instr_dst, instr_io_addr} <= {d, ia};
        instr_op <= o;
        do @(posedge pclk); while (instr_ready !== 1'b1);
        {r, io, s, p} = {reg_rdata, io_rdata, status_register, pc};
        instr_valid <= 1'b0;
        tk = br_take(o, f, s);
        ep = tk ? p + 12'd1 + {{5{off[6]}}, off} : p + 12'd1;
        {er, eio, es} = {r, io, s};
        case (o)
            op_io_bit_force_one:        eio[b] = 1'b1;
            op_io_bit_force_zero:       eio[b] = 1'b0;
            op_shift_left_logical:      {es[FLAG_C], er} = {r, 1'b0};
            op_shift_right_logical:     {er, es[FLAG_C]} = {1'b0, r};
            op_rotate_left_carry:       {es[FLAG_C], er} = {r, s[FLAG_C]};
            op_rotate_right_carry:      {er, es[FLAG_C]} = {s[FLAG_C], r};
            op_shift_right_arith:       {er, es[FLAG_C]} = {r[7], r};
            op_bit_to_transfer_flag:    es[FLAG_T] = r[b];
            op_transfer_flag_to_bit:    er[b] = s[FLAG_T];
            op_flag_force_one_indexed,
            op_flag_force_one_named:    es[f] = 1'b1;
            op_flag_force_zero_indexed,
            op_flag_force_zero_named:   es[f] = 1'b0;
            op_global_irq_on:           es[FLAG_I] = 1'b1;
            op_global_irq_off:          es[FLAG_I] = 1'b0;
            default:                    ;
        endcase
        wr = o inside {[op_shift_left_logical:op_shift_right_arith], op_transfer_flag_to_bit};
        wi = o inside {op_io_bit_force_one, op_io_bit_force_zero};
        if (wr && o != op_transfer_flag_to_bit)
            {es[FLAG_V], es[FLAG_Z], es[FLAG_N]} = {er[7] ^ es[FLAG_C], er == 8'h00, er[7]};
        @(negedge pclk);
        chk(pc, ep);
        chk(pc_load, tk);
        chk(status_register, es);
        chk({rd_we, rd_waddr, rd_wdata}, wr ? {1'b1, d, er} : {1'b0, rd_waddr, rd_wdata});
        chk({io_we, io_waddr, io_wdata}, wi ? {1'b1, ia, eio} : {1'b0, io_waddr, io_wdata});
        @(posedge pclk);
    endtask

    // Reset, registers, every operation but op_nop, edge offsets, random mix
    initial begin
        seed = 89772;
        {mismatches, total_checks} = '0;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {instr_valid, instr_flag, instr_bit, instr_offset, instr_dst, instr_io_addr} = '0;
        instr_op = op_nop;
        ce = 1'b1;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0, {24'h0, STATUS_RST}, 1'b0);
        apb(1'b0, ADDR_CTRL, 32'h0, 32'(CTRL_RUN_RST), 1'b0);
        apb(1'b0, ADDR_PC, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);
        apb(1'b0, ADDR_COUNT, 32'h0, 32'h0, 1'b0);
        for (int k = 1; k < 36; k++)
            op(op_t'(k), 8'($random(seed)), 7'($random(seed)));
        for (int k = 1; k < 21; k++) begin
            op(op_t'(k), 8'h00, 7'h40);
            op(op_t'(k), 8'hff, 7'h3f);
        end
        repeat (250)
            op(op_t'(1 + $unsigned($random(seed)) % 35), 8'($random(seed)), 7'($random(seed)));
        apb(1'b0, ADDR_COUNT, 32'h0, 32'd325, 1'b0);
        give_verdict();
    end

    // Cuts a hang short
    initial begin
        #300us;
        mismatches++;
        give_verdict();
    end
endmodule
